// ===== hdl/ccp_pkg.sv
// Shared constants and types for the clock generator control port
package ccp_pkg;

  // Target addresses picked by the captured address-select level
  localparam logic [6:0] TGT_ADDR_SEL0 = 7'h69;
  localparam logic [6:0] TGT_ADDR_SEL1 = 7'h6A;

  // Command byte layout
  localparam int CMD_MODE_BIT = 7;

  // Register file shape and power-up contents
  localparam int NUM_REGS = 6;
  localparam logic [6:0] REG_RO_IDX = 7'h05;
  // Revision code held in the read-only byte; value arbitrary
  localparam logic [7:0] REV_CODE = 8'h00;
  localparam logic [NUM_REGS-1:0][7:0] REG_DEFAULTS = {
    REV_CODE, 8'hF8, 8'hFF, 8'h2B, 8'hF0, 8'hFF
  };

  // Byte count the target announces in a block read
  localparam logic [7:0] BLOCK_RD_COUNT = 8'h06;

  // Reference clock timing
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int REF_FREQ_HZ = 25_000_000;
  localparam int REF_HALF_RAW = CLK_FREQ_HZ / (2 * REF_FREQ_HZ);
  localparam int REF_HALF_CYC = (REF_HALF_RAW < 1) ? 1 : REF_HALF_RAW;
  localparam int REF_CNT_W = 4;

  typedef enum logic [2:0] {
    L_IDLE,
    L_RX,
    L_ACK,
    L_TX,
    L_RACK
  } ccp_lnk_st_t;

  typedef enum logic [1:0] {
    RX_ADDR,
    RX_CMD,
    RX_CNT,
    RX_DATA
  } ccp_rx_t;

endpackage

// ===== hdl/ccp_sync.sv
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/100ps
`default_nettype none
module ccp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ccp_sync_st_t;

  ccp_sync_st_t s_r;
  ccp_sync_st_t s_nxt;

  always_comb begin
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  // No reset: a reset would only delay the first valid sample
  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign q = s_r.s2;
endmodule
`default_nettype wire

// ===== hdl/ccp_i2c_target.sv
// Two-wire target port and control byte file of the clock generator
//
// Overview of operation
// - Address-select pin level is captured once after reset and then held.
// - Select 0 answers address 1101001, select 1 answers 1101010.
// - An undriven select pin reads high, giving select value 1.
// - After capture the shared pin turns output and carries the reference clock.
// - Every control byte takes its default value at reset.
// - Block bytes go to ascending registers, MSB first, stop allowed after any byte.
// - Command top bit 0 means block mode; low seven bits give start index.
// - Target acknowledges every block write byte; controller then stops.
// - Block read: repeated start, read address, then target sends nonzero count.
// - Count byte first, then data; controller acks all but last, then stops.
// - Command top bit 1 means single byte: no count, only selected register.
// - Single write: address, command, one data byte, each acknowledged.
// - Single read: repeated start, one data byte returned, then not-ack and stop.
`timescale 1ns/100ps
`default_nettype none
module ccp_i2c_target
  import ccp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic LINK_CLK,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic ADDR_SEL_REF_IN,
  output logic ADDR_SEL_REF_OUT,
  output logic ADDR_SEL_REF_OE,
  output logic ADDR_SEL_CAPTURED,
  output logic [8*NUM_REGS-1:0] CTRL_REGS
);

  // Core domain state
  typedef struct packed {
    logic cap_done;
    logic addr_sel;
    logic ref_oe;
    logic ref_out;
    logic [REF_CNT_W-1:0] ref_cnt;
    logic req_q;
    logic ack_tgl;
    logic [7:0] rdata;
    logic [NUM_REGS-1:0][7:0] regs;
  } ccp_core_t;

  // Link domain state
  typedef struct packed {
    ccp_lnk_st_t st;
    ccp_rx_t rx;
    logic scl_q;
    logic sda_q;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic byte_mode;
    logic cnt_sent;
    logic wr_done;
    logic nack;
    logic [6:0] idx;
    logic sda_oe;
    logic req_tgl;
    logic req_wr;
    logic [6:0] req_idx;
    logic [7:0] req_wdata;
    logic [7:0] rbuf;
    logic ack_q;
  } ccp_lnk_t;

  localparam logic [REF_CNT_W-1:0] REF_HALF_LAST = REF_CNT_W'(REF_HALF_CYC - 1);
  localparam logic [6:0] NUM_REGS_IDX = 7'(NUM_REGS);

  ccp_core_t c_r;
  ccp_core_t c_nxt;
  ccp_lnk_t l_r;
  ccp_lnk_t l_nxt;

  logic [1:0] core_in_s;
  logic [5:0] lnk_in_s;
  logic pin_s;
  logic req_s;
  logic rst_l;
  logic scl_s;
  logic sda_s;
  logic ready_s;
  logic sel_s;
  logic ack_s;

  // Toggles, reset, bus lines and pin pass two flops first; request fields and rdata are read directly
  ccp_sync #(.WIDTH(2)) u_core_sync (
    .clk(CLK),
    .d({ADDR_SEL_REF_IN, l_r.req_tgl}),
    .q(core_in_s)
  );

  ccp_sync #(.WIDTH(6)) u_lnk_sync (
    .clk(LINK_CLK),
    .d({RST, SCL_IN, SDA_IN, c_r.cap_done, c_r.addr_sel, c_r.ack_tgl}),
    .q(lnk_in_s)
  );

  assign pin_s = core_in_s[1];
  assign req_s = core_in_s[0];
  assign rst_l = lnk_in_s[5];
  assign scl_s = lnk_in_s[4];
  assign sda_s = lnk_in_s[3];
  assign ready_s = lnk_in_s[2];
  assign sel_s = lnk_in_s[1];
  assign ack_s = lnk_in_s[0];

  // Core domain
  always_comb begin
    c_nxt = c_r;
    if (!c_r.cap_done) begin
      // Pin is still an input here; pull-up makes an open pin read 1
      c_nxt.cap_done = 1'b1;
      c_nxt.addr_sel = pin_s;
    end else begin
      c_nxt.ref_oe = 1'b1;
      if (c_r.ref_cnt == REF_HALF_LAST) begin
        c_nxt.ref_cnt = '0;
        c_nxt.ref_out = ~c_r.ref_out;
      end else begin
        c_nxt.ref_cnt = c_r.ref_cnt + 1'b1;
      end
    end
    // Link request fields stay still until the acknowledge returns
    if (req_s != c_r.req_q) begin
      c_nxt.req_q = req_s;
      c_nxt.ack_tgl = ~c_r.ack_tgl;
      if (l_r.req_idx < NUM_REGS_IDX) begin
        c_nxt.rdata = c_r.regs[l_r.req_idx[2:0]];
        if (l_r.req_wr && l_r.req_idx != REG_RO_IDX) begin
          c_nxt.regs[l_r.req_idx[2:0]] = l_r.req_wdata;
        end
      end else begin
        c_nxt.rdata = '0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      c_r.cap_done <= 1'b0;
      c_r.addr_sel <= 1'b1;
      c_r.ref_oe <= 1'b0;
      c_r.ref_out <= 1'b0;
      c_r.ref_cnt <= '0;
      c_r.req_q <= 1'b0;
      c_r.ack_tgl <= 1'b0;
      c_r.rdata <= '0;
      c_r.regs <= REG_DEFAULTS;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign ADDR_SEL_REF_OUT = c_r.ref_out;
  assign ADDR_SEL_REF_OE = c_r.ref_oe;
  assign ADDR_SEL_CAPTURED = c_r.addr_sel;
  assign CTRL_REGS = c_r.regs;

  // Link domain
  // Loads the next byte to send and drives its MSB at once
  function automatic ccp_lnk_t load_tx(input ccp_lnk_t x);
    ccp_lnk_t y;
    logic [7:0] b;
    y = x;
    if (!x.byte_mode && !x.cnt_sent) begin
      b = BLOCK_RD_COUNT;
      y.cnt_sent = 1'b1;
    end else begin
      b = x.rbuf;
      if (!x.byte_mode) begin
        // Prefetch the next index while this byte goes out
        y.idx = x.idx + 1'b1;
        y.req_tgl = ~x.req_tgl;
        y.req_wr = 1'b0;
        y.req_idx = x.idx + 1'b1;
      end
    end
    y.shreg = b;
    y.sda_oe = ~b[7];
    y.bitcnt = 4'h1;
    y.st = L_TX;
    return y;
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [6:0] my_addr;

  assign scl_rise = scl_s & ~l_r.scl_q;
  assign scl_fall = ~scl_s & l_r.scl_q;
  assign start_c = scl_s & l_r.scl_q & l_r.sda_q & ~sda_s;
  assign stop_c = scl_s & l_r.scl_q & ~l_r.sda_q & sda_s;
  assign my_addr = sel_s ? TGT_ADDR_SEL1 : TGT_ADDR_SEL0;

  always_comb begin
    l_nxt = l_r;
    l_nxt.scl_q = scl_s;
    l_nxt.sda_q = sda_s;
    if (ack_s != l_r.ack_q) begin
      l_nxt.ack_q = ack_s;
      l_nxt.rbuf = c_r.rdata;
    end
    if (start_c && ready_s) begin
      // Also taken as a repeated start in the middle of a transfer
      l_nxt.st = L_RX;
      l_nxt.rx = RX_ADDR;
      l_nxt.bitcnt = '0;
      l_nxt.sda_oe = 1'b0;
    end else if (stop_c) begin
      l_nxt.st = L_IDLE;
      l_nxt.sda_oe = 1'b0;
    end else begin
      case (l_r.st)
        L_IDLE: begin
        end
        L_RX: begin
          if (scl_rise) begin
            l_nxt.shreg = {l_r.shreg[6:0], sda_s};
            l_nxt.bitcnt = l_r.bitcnt + 1'b1;
          end else if (scl_fall && l_r.bitcnt == 4'h8) begin
            l_nxt.bitcnt = '0;
            l_nxt.sda_oe = 1'b1;
            l_nxt.st = L_ACK;
            case (l_r.rx)
              RX_ADDR: begin
                l_nxt.rw = l_r.shreg[0];
                l_nxt.cnt_sent = 1'b0;
                l_nxt.wr_done = 1'b0;
                if (l_r.shreg[7:1] != my_addr) begin
                  l_nxt.sda_oe = 1'b0;
                  l_nxt.st = L_IDLE;
                end
              end
              RX_CMD: begin
                l_nxt.byte_mode = l_r.shreg[CMD_MODE_BIT];
                l_nxt.idx = l_r.shreg[6:0];
                l_nxt.req_tgl = ~l_r.req_tgl;
                l_nxt.req_wr = 1'b0;
                l_nxt.req_idx = l_r.shreg[6:0];
              end
              RX_CNT: begin
                // Count is acknowledged; data length follows the stop
              end
              RX_DATA: begin
                if (!(l_r.byte_mode && l_r.wr_done)) begin
                  l_nxt.req_tgl = ~l_r.req_tgl;
                  l_nxt.req_wr = 1'b1;
                  l_nxt.req_idx = l_r.idx;
                  l_nxt.req_wdata = l_r.shreg;
                  l_nxt.wr_done = 1'b1;
                end
                if (!l_r.byte_mode) begin
                  l_nxt.idx = l_r.idx + 1'b1;
                end
              end
              default: begin
              end
            endcase
          end
        end
        L_ACK: begin
          if (scl_fall) begin
            l_nxt.sda_oe = 1'b0;
            l_nxt.st = L_RX;
            case (l_r.rx)
              RX_ADDR: begin
                if (l_r.rw) begin
                  l_nxt = load_tx(l_nxt);
                end else begin
                  l_nxt.rx = RX_CMD;
                end
              end
              RX_CMD: l_nxt.rx = l_r.byte_mode ? RX_DATA : RX_CNT;
              default: l_nxt.rx = RX_DATA;
            endcase
          end
        end
        L_TX: begin
          if (scl_fall) begin
            if (l_r.bitcnt == 4'h8) begin
              l_nxt.sda_oe = 1'b0;
              l_nxt.st = L_RACK;
            end else begin
              l_nxt.shreg = {l_r.shreg[6:0], 1'b0};
              l_nxt.sda_oe = ~l_r.shreg[6];
              l_nxt.bitcnt = l_r.bitcnt + 1'b1;
            end
          end
        end
        L_RACK: begin
          if (scl_rise) begin
            l_nxt.nack = sda_s;
          end else if (scl_fall) begin
            if (l_r.nack) begin
              l_nxt.st = L_IDLE;
            end else begin
              l_nxt = load_tx(l_nxt);
            end
          end
        end
        default: l_nxt.st = L_IDLE;
      endcase
    end
  end

  // Link reset lags the core reset by two link clocks
  always_ff @(posedge LINK_CLK) begin
    if (rst_l) begin
      l_r.st <= L_IDLE;
      l_r.rx <= RX_ADDR;
      // Bus idles high; a low reset value would fake an edge
      l_r.scl_q <= 1'b1;
      l_r.sda_q <= 1'b1;
      l_r.bitcnt <= '0;
      l_r.shreg <= '0;
      l_r.rw <= 1'b0;
      l_r.byte_mode <= 1'b0;
      l_r.cnt_sent <= 1'b0;
      l_r.wr_done <= 1'b0;
      l_r.nack <= 1'b0;
      l_r.idx <= '0;
      l_r.sda_oe <= 1'b0;
      l_r.req_tgl <= 1'b0;
      l_r.req_wr <= 1'b0;
      l_r.req_idx <= '0;
      l_r.req_wdata <= '0;
      l_r.rbuf <= '0;
      l_r.ack_q <= 1'b0;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE = l_r.sda_oe;

endmodule
`default_nettype wire

// ===== verif/ccp_i2c_target_chk.sv
// Port checker for the control port
`timescale 1ns/100ps
`default_nettype none
module ccp_i2c_target_chk
  import ccp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic LINK_CLK,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic ADDR_SEL_REF_IN,
  input wire logic ADDR_SEL_REF_OUT,
  input wire logic ADDR_SEL_REF_OE,
  input wire logic ADDR_SEL_CAPTURED,
  input wire logic [8*NUM_REGS-1:0] CTRL_REGS
);
  a_sda_never_high: assert property (@(posedge CLK) disable iff (RST) !SDA_OUT)
    else $error("sda driven high");
  a_reset_levels: assert property (@(posedge CLK) RST ##1 RST ##1 RST |->
    !SDA_OE && !ADDR_SEL_REF_OE && !ADDR_SEL_REF_OUT && ADDR_SEL_CAPTURED)
    else $error("bad reset levels");
  a_reg_defaults: assert property (@(posedge CLK) disable iff (RST)
    $fell(RST) |-> CTRL_REGS == REG_DEFAULTS) else $error("bad defaults");
  a_capture_pin: assert property (@(posedge CLK) disable iff (RST)
    $fell(RST) |=> ADDR_SEL_CAPTURED == $past(ADDR_SEL_REF_IN, 3))
    else $error("bad capture");
  a_ref_enable: assert property (@(posedge CLK) disable iff (RST)
    $fell(RST) |-> ##[1:3] ADDR_SEL_REF_OE) else $error("ref not enabled");
  a_capture_held: assert property (@(posedge CLK) disable iff (RST)
    ADDR_SEL_REF_OE |=> $stable(ADDR_SEL_CAPTURED)) else $error("capture moved");
  a_ref_toggles: assert property (@(posedge CLK) disable iff (RST)
    ADDR_SEL_REF_OE && $past(ADDR_SEL_REF_OE) |-> ADDR_SEL_REF_OUT != $past(ADDR_SEL_REF_OUT))
    else $error("ref stuck");
  a_ro_byte_kept: assert property (@(posedge CLK) disable iff (RST)
    $stable(CTRL_REGS[8*NUM_REGS-1 -: 8])) else $error("read-only byte changed");
  a_oe_scl_low: assert property (@(posedge LINK_CLK) disable iff (RST)
    $changed(SDA_OE) |-> !SCL_IN) else $error("sda moved with scl high");
endmodule
bind ccp_i2c_target ccp_i2c_target_chk u_chk (.CLK(CLK), .RST(RST), .LINK_CLK(LINK_CLK),
  .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .ADDR_SEL_REF_IN(ADDR_SEL_REF_IN), .ADDR_SEL_REF_OUT(ADDR_SEL_REF_OUT),
  .ADDR_SEL_REF_OE(ADDR_SEL_REF_OE), .ADDR_SEL_CAPTURED(ADDR_SEL_CAPTURED),
  .CTRL_REGS(CTRL_REGS));
`default_nettype wire

// ===== verif/ccp_host.sv
// Bus controller model for the control port
`timescale 1ns/100ps
`default_nettype none
module ccp_host (
  output logic scl,
  output logic pull,
  input wire logic sda
);
  localparam int HP = 2200; // Target needs 2 us per clock phase
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Also the repeated start; data moves mid low phase, clear of clock edges
  task automatic start();
    #(HP/2) pull = 1'b0;
    #(HP/2) scl = 1'b1;
    #HP pull = 1'b1;
    #HP scl = 1'b0;
  endtask
  task automatic stop();
    #(HP/2) pull = 1'b1;
    #(HP/2) scl = 1'b1;
    #HP pull = 1'b0;
    #HP;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #(HP/2) pull = !b;
    #(HP/2) scl = 1'b1;
    #HP r = sda;
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]); // Msb first
    bit_io(ak, a); // Nack only the last read byte
  endtask
endmodule
`default_nettype wire

// ===== verif/ccp_i2c_target_tb.sv
// Self-checking bench for the control port
`timescale 1ns/100ps
`default_nettype none
module ccp_i2c_target_tb
  import ccp_pkg::*;
();
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b1;
  logic scl, pull, sda_oe, sda_out, ref_out, ref_oe, capt, r0;
  logic [8*NUM_REGS-1:0] regs, mdl;
  logic [6:0] addr;
  int seed = 33;
  int fail_count = 0;
  int checks_done = 0;
  wire logic sda = !(pull || (sda_oe && !sda_out)); // Pull-up on the data line
  wire logic pin = ref_oe ? ref_out : strap; // Strap resistor when undriven
  always #50 clk = !clk;
  // Offset keeps link edges clear of core edges and bus changes
  initial begin
    #7;
    forever #15 lclk = !lclk;
  end
  ccp_host u_host (.scl(scl), .pull(pull), .sda(sda));
  ccp_i2c_target u_dut (.CLK(clk), .RST(rst), .LINK_CLK(lclk), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SEL_REF_IN(pin), .ADDR_SEL_REF_OUT(ref_out),
    .ADDR_SEL_REF_OE(ref_oe), .ADDR_SEL_CAPTURED(capt), .CTRL_REGS(regs));
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] rd_exp(input int i);
    return (i < NUM_REGS) ? mdl[8*i +: 8] : 8'h00;
  endfunction
  task automatic wr_mdl(input int i, input logic [7:0] d);
    if (i < NUM_REGS && i != REG_RO_IDX) mdl[8*i +: 8] = d;
  endtask
  task automatic settle();
    for (int n = 0; n < 50 && regs !== mdl; n++) @(negedge clk);
    check(regs, mdl);
  endtask
  task automatic sb(input logic [7:0] d);
    logic [7:0] q;
    logic a;
    u_host.xfer(d, 1'b1, q, a);
    check(a, 1'b0);
  endtask
  task automatic head(input logic [7:0] cmd);
    u_host.start();
    sb({addr, 1'b0});
    sb(cmd);
  endtask
  task automatic miss(input logic [6:0] wa);
    logic [7:0] q;
    logic a;
    u_host.start();
    u_host.xfer({wa, 1'b0}, 1'b1, q, a);
    check(a, 1'b1);
    u_host.stop();
  endtask
  task automatic blk_wr(input logic [6:0] ix, input int n);
    logic [7:0] d;
    head({1'b0, ix});
    sb(8'(n));
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      sb(d);
      wr_mdl(ix + i, d);
    end
    u_host.stop();
    settle();
  endtask
  task automatic blk_rd(input logic [6:0] ix, input int n);
    logic [7:0] q;
    logic a;
    head({1'b0, ix});
    u_host.start();
    sb({addr, 1'b1});
    u_host.xfer(8'hFF, 1'b0, q, a);
    check(q, BLOCK_RD_COUNT);
    for (int i = 0; i < n; i++) begin
      u_host.xfer(8'hFF, i == n - 1, q, a);
      check(q, rd_exp(ix + i));
    end
    u_host.stop();
  endtask
  task automatic byte_op(input logic [6:0] ix, input logic [7:0] d);
    logic [7:0] q;
    logic a;
    head({1'b1, ix});
    sb(d);
    u_host.stop();
    wr_mdl(ix, d);
    settle();
    head({1'b1, ix});
    u_host.start();
    sb({addr, 1'b1});
    u_host.xfer(8'hFF, 1'b1, q, a);
    check(q, rd_exp(ix));
    u_host.stop();
  endtask
  task automatic do_reset(input logic s);
    // Align first, so reset always spans three rising edges
    @(negedge clk);
    strap = s;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    addr = s ? TGT_ADDR_SEL1 : TGT_ADDR_SEL0;
    mdl = REG_DEFAULTS;
    repeat (20) @(negedge clk);
    check(capt, s);
    check(regs, REG_DEFAULTS);
    check(ref_oe, 1'b1);
    r0 = ref_out;
    @(negedge clk);
    check(ref_out, !r0);
    $display("reset with strap %0b done", s);
  endtask
  initial begin
    do_reset(1'b1);
    miss(TGT_ADDR_SEL0);
    blk_wr(7'h00, 6);
    blk_rd(7'h00, 6);
    for (int k = 0; k < 3; k++) begin
      blk_wr(7'({$random(seed)} % 8), 1 + {$random(seed)} % 6);
      blk_rd(7'({$random(seed)} % 8), 1 + {$random(seed)} % 6);
    end
    $display("block tests done");
    byte_op(7'h05, 8'h5A);
    byte_op(7'h7F, 8'hC3);
    byte_op(7'h02, 8'($random(seed)));
    $display("byte tests done");
    do_reset(1'b0);
    miss(TGT_ADDR_SEL1);
    byte_op(7'h01, 8'hA5);
    blk_rd(7'h00, 6);
    $display("strap low tests done");
    test_done();
  end
  initial begin
    #9_000_000;
    fail_count++;
    $display("[FAIL] %0t run timed out", $time);
    test_done();
  end
endmodule
`default_nettype wire
